// >>> logic/window_decode_pkg.sv
// shared constants and carriers for the configuration window base decoders
// assumes a single 250 mhz host bridge clock and synchronous active-low reset
package window_decode_pkg;
    // configuration space offsets (byte addresses of the low dword)
    localparam logic [7:0] INGRESS_BASE_OFS = 8'h68;
    localparam logic [7:0] TRUSTED_BASE_OFS = 8'h80;
    localparam logic [7:0] RC_CTRL_OFS = 8'h54;
    localparam logic [7:0] ENH_CFG_BASE_OFS = 8'h60;

    // field positions
    localparam int RC_GLOBAL_EN_BIT = 29;
    localparam int INGRESS_EN_BIT = 0;
    localparam int INGRESS_LO = 12;
    localparam int ADDR_HI = 35;
    localparam int TRUSTED_LO = 28;
    localparam int MASK128_BIT = 27;
    localparam int MASK64_BIT = 26;
    localparam int LEN_LO = 1;
    localparam int BUS_LO = 20;
    localparam int DEV_LO = 15;
    localparam int FUNC_LO = 12;

    // values after reset
    localparam logic [63:0] INGRESS_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] TRUSTED_RESET = 64'h0000_0000_e000_0000;

    // window length encodings
    typedef enum logic [1:0]
    {
        LEN_256MB = 2'b00,
        LEN_128MB = 2'b01,
        LEN_64MB = 2'b10,
        LEN_RSVD = 2'b11
    } win_len_type;

    // configuration write carrier
    typedef struct packed
    {
        logic valid;
        logic [7:0] offset;
        logic [31:0] data;
        logic [3:0] byte_en;
    } cfg_write_type;

    // memory transaction carrier
    typedef struct packed
    {
        logic valid;
        logic [35:0] addr;
    } mem_req_type;

    // decode result carrier
    typedef struct packed
    {
        logic ingress_hit;
        logic trusted_hit;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
        logic [11:0] reg_ofs;
    } decode_type;
endpackage

// >>> logic/trusted_decode.sv
// trusted window address decoder: match and bus/device/function split
// assumes base comes from a register in the parent and length from its enh_cfg_len_in input
module trusted_decode
    import window_decode_pkg::*;
(
    // window setup
    input wire logic [9:0] base_in,
    input wire window_decode_pkg::win_len_type len_in,
    // address
    input wire logic [35:0] addr_in,
    // result
    output logic hit_out,
    output logic [7:0] bus_out,
    output logic [4:0] dev_out,
    output logic [2:0] func_out
);
    logic [9:0] cmp_mask;

    // only bits above the window size compare: 35:28, 35:27 or 35:26
    always_comb
    begin
        unique case (len_in)
            LEN_256MB: cmp_mask = 10'h3fc;
            LEN_128MB: cmp_mask = 10'h3fe;
            LEN_64MB: cmp_mask = 10'h3ff;
            default: cmp_mask = 10'h000;
        endcase
    end

    // reserved length never matches, so the trusted window claims nothing
    assign hit_out = (len_in != LEN_RSVD) &&
        (((addr_in[35:26] ^ base_in) & cmp_mask) == 10'h000);

    // bus at 1 mb, device at 32 kb, function at 4 kb granularity
    always_comb
    begin
        bus_out = addr_in[27:20];
        if (len_in == LEN_128MB)
        begin
            bus_out = {1'b0, addr_in[26:20]};
        end
        else if (len_in == LEN_64MB)
        begin
            bus_out = {2'b00, addr_in[25:20]};
        end
    end
    assign dev_out = addr_in[19:15];
    assign func_out = addr_in[14:12];
endmodule

// >>> logic/config_window_base_decoders.sv
// two 64-bit window base registers and their memory decoders
// assumes config writes and memory requests are synchronous to ref_clk_in
//
// Notes on behaviour
// - ingress window resets disabled; decodes only when global enable bit 29 is set
// - ingress enable bit 0 gates all claims of the ingress window
// - ingress base holds address bits 35:12 and compares them against the request
// - ingress hits route only to the root complex register set
// - ingress window must not alias any other decoded memory range; not checked here, an overlap with the trusted window is claimed by ingress
// - lock mode makes every writable bit of both registers read-only
// - trusted base field sits at bits 35:28 and resets to 0e
// - trusted window size follows the enhanced window length field
// - trusted decoder compares only bits above the window size
// - offset splits into bus, device and function fields
// - each 4 kb function slot is one contiguous configuration space
// - trusted hits become configuration accesses, never memory
// - length 00 is 256 mb, 01 128 mb, 10 64 mb, 11 reserved
// - bits 27 and 26 are base bits or read-zero mask bits by length
module config_window_base_decoders
    import window_decode_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // configuration write port
    input wire window_decode_pkg::cfg_write_type cfg_wr_in,
    // configuration read port
    input wire logic [7:0] cfg_rd_offset_in,
    output logic [31:0] cfg_rd_data_out,
    // shared state from elsewhere in the host bridge
    input wire logic lock_mode_in,
    input wire logic rc_global_enable_in,
    input wire window_decode_pkg::win_len_type enh_cfg_len_in,
    // memory request and decode result
    input wire window_decode_pkg::mem_req_type mem_req_in,
    output window_decode_pkg::decode_type decode_out,
    output logic claimed_out
);
    import window_decode_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [23:0] ingress_base_r;
    logic ingress_en_r;
    logic [27:0] ingress_upper_r;
    logic [9:0] trusted_base_r;
    logic [27:0] trusted_upper_r;
    logic [31:0] rd_data_nxt;
    logic t_hit;
    logic i_hit;
    logic [7:0] t_bus;
    logic [4:0] t_dev;
    logic [2:0] t_func;
    logic [9:0] trusted_view;

    // byte-lane merge of a write into a 32-bit value
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
        input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // mask bits that the length turns into read-zero address mask
    function automatic logic [9:0] len_mask(input win_len_type len);
        logic [9:0] m;
        // 256 mb and reserved: bits 27 and 26 both read zero
        m = 10'h3fc;
        if (len == LEN_128MB)
        begin
            m = 10'h3fe;
        end
        else if (len == LEN_64MB)
        begin
            m = 10'h3ff;
        end
        return m;
    endfunction

    logic wr_ok;
    logic [31:0] ing_lo_cur;
    logic [31:0] ing_lo_new;
    logic [31:0] tr_lo_cur;
    logic [31:0] tr_lo_new;
    logic [31:0] tr_lo_raw;
    logic [31:0] ing_hi_new;
    logic [31:0] tr_hi_new;

    ////////////////////////////////////////////////////////////////////////
    // lock mode swallows writes so stored values never move
    assign wr_ok = cfg_wr_in.valid && !lock_mode_in;
    assign ing_lo_cur = {ingress_base_r[19:0], 11'h000, ingress_en_r};
    assign ing_lo_new = merge(ing_lo_cur, cfg_wr_in.data, cfg_wr_in.byte_en);
    assign ing_hi_new = merge({ingress_upper_r, ingress_base_r[23:20]}, cfg_wr_in.data,
        cfg_wr_in.byte_en);
    assign tr_lo_cur = {trusted_view[5:0], 26'h0};
    // merge against stored bits so a partial write keeps hidden mask bits
    assign tr_lo_raw = {trusted_base_r[5:0], 26'h0};
    assign tr_lo_new = merge(tr_lo_raw, cfg_wr_in.data, cfg_wr_in.byte_en);
    assign tr_hi_new = merge({trusted_upper_r, trusted_base_r[9:6]}, cfg_wr_in.data,
        cfg_wr_in.byte_en);

    ////////////////////////////////////////////////////////////////////////
    // ingress window register, reset disabled
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            ingress_base_r <= INGRESS_RESET[35:12];
            ingress_en_r <= INGRESS_RESET[0];
            ingress_upper_r <= INGRESS_RESET[63:36];
        end
        else if (wr_ok && cfg_wr_in.offset == INGRESS_BASE_OFS)
        begin
            // bits 11:1 are reserved and never stored
            ingress_base_r[19:0] <= ing_lo_new[31:12];
            ingress_en_r <= ing_lo_new[INGRESS_EN_BIT];
        end
        else if (wr_ok && cfg_wr_in.offset == INGRESS_BASE_OFS + 8'h04)
        begin
            ingress_base_r[23:20] <= ing_hi_new[3:0];
            ingress_upper_r <= ing_hi_new[31:4]; // plain storage, no decode
        end
    end

    // trusted window register, base resets to 0e in bits 35:28
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            trusted_base_r <= TRUSTED_RESET[ADDR_HI:MASK64_BIT];
            trusted_upper_r <= TRUSTED_RESET[63:36];
        end
        else if (wr_ok && cfg_wr_in.offset == TRUSTED_BASE_OFS)
        begin
            // bits 27:26 kept while masked, so a later length change sees them
            trusted_base_r[5:0] <= tr_lo_new[31:26];
        end
        else if (wr_ok && cfg_wr_in.offset == TRUSTED_BASE_OFS + 8'h04)
        begin
            trusted_base_r[9:6] <= tr_hi_new[3:0];
            // bits 63:36 are plain storage but locked as well
            trusted_upper_r <= tr_hi_new[31:4];
        end
    end

    // mask bits read zero by current length; stored bit kept underneath
    assign trusted_view = trusted_base_r & len_mask(enh_cfg_len_in);

    ////////////////////////////////////////////////////////////////////////
    // register read mux; unmapped offsets read zero
    always_comb
    begin
        rd_data_nxt = 32'h0000_0000;
        unique case (cfg_rd_offset_in)
            INGRESS_BASE_OFS: rd_data_nxt = ing_lo_cur;
            INGRESS_BASE_OFS + 8'h04: rd_data_nxt = {ingress_upper_r, ingress_base_r[23:20]};
            TRUSTED_BASE_OFS: rd_data_nxt = tr_lo_cur;
            TRUSTED_BASE_OFS + 8'h04: rd_data_nxt = {trusted_upper_r, trusted_base_r[9:6]};
            default: rd_data_nxt = 32'h0000_0000;
        endcase
    end

    // read data registered, one cycle after the offset is presented
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            cfg_rd_data_out <= 32'h0000_0000;
        end
        else
        begin
            cfg_rd_data_out <= rd_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trusted decoder sized by the enhanced window length
    // masked view in, so hidden mask bits never join the match
    trusted_decode u_trusted_decode
    (
        .base_in(trusted_view),
        .len_in(enh_cfg_len_in),
        .addr_in(mem_req_in.addr),
        .hit_out(t_hit),
        .bus_out(t_bus),
        .dev_out(t_dev),
        .func_out(t_func)
    );

    // ingress hit needs global and local enables and a 35:12 match
    assign i_hit = mem_req_in.valid && rc_global_enable_in && ingress_en_r &&
        (mem_req_in.addr[35:12] == ingress_base_r);

    // registered decode result; ingress wins if software overlaps them
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            decode_out <= '0;
        end
        else
        begin
            // fields load every cycle; only the hit bits qualify them
            decode_out.ingress_hit <= i_hit; // routes to register set only
            decode_out.trusted_hit <= mem_req_in.valid && t_hit && !i_hit;
            decode_out.bus <= t_bus;
            decode_out.dev <= t_dev;
            decode_out.func <= t_func;
            decode_out.reg_ofs <= mem_req_in.addr[11:0]; // one 4 kb slot
        end
    end

    // unclaimed requests fall through to normal memory routing
    assign claimed_out = decode_out.ingress_hit || decode_out.trusted_hit;
endmodule

// >>> verification/config_window_base_decoders_props.sv
// checker for the two window decoders, sees only the top module ports
// assumes one clock domain and a registered one-cycle decode latency
module config_window_base_decoders_props
    import window_decode_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // watched ports
    input wire window_decode_pkg::cfg_write_type cfg_wr_in,
    input wire logic [7:0] cfg_rd_offset_in,
    input wire logic [31:0] cfg_rd_data_out,
    input wire logic lock_mode_in,
    input wire logic rc_global_enable_in,
    input wire window_decode_pkg::win_len_type enh_cfg_len_in,
    input wire window_decode_pkg::mem_req_type mem_req_in,
    input wire window_decode_pkg::decode_type decode_out,
    input wire logic claimed_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////
    logic [7:0] bus_exp_r;
    // expected bus number, masked by the length in force at the request
    always_ff @(posedge ref_clk_in)
    begin
        bus_exp_r <= mem_req_in.addr[27:20] & (8'hff >> enh_cfg_len_in);
    end
    // locked write aimed at the offset being read, then a quiet cycle
    sequence s_locked_wr;
        lock_mode_in && cfg_wr_in.valid && cfg_rd_offset_in == cfg_wr_in.offset;
    endsequence
    sequence s_quiet_rd;
        $stable(cfg_rd_offset_in) && !cfg_wr_in.valid;
    endsequence
    ////////////////////////////////////////////////////////////
    a_claim_is_or: assert property (claimed_out ==
        (decode_out.ingress_hit | decode_out.trusted_hit)) else $error("claim mismatch");
    a_idle_unclaimed: assert property (!mem_req_in.valid |=> !claimed_out)
        else $error("claim without request");
    a_ingress_enabled: assert property (decode_out.ingress_hit |->
        $past(rc_global_enable_in) && $past(mem_req_in.valid)) else $error("ingress hit gated");
    a_global_off_quiet: assert property (!rc_global_enable_in |=> !decode_out.ingress_hit)
        else $error("ingress hit with global off");
    a_single_target: assert property (!(decode_out.ingress_hit && decode_out.trusted_hit))
        else $error("two targets claimed");
    a_rsvd_no_trust: assert property (enh_cfg_len_in == LEN_RSVD |=> !decode_out.trusted_hit)
        else $error("reserved length hit");
    a_slot_fields: assert property (decode_out.trusted_hit |->
        {decode_out.dev, decode_out.func, decode_out.reg_ofs} == $past(mem_req_in.addr[19:0]))
        else $error("slot fields wrong");
    a_bus_by_len: assert property (decode_out.trusted_hit |-> decode_out.bus == bus_exp_r)
        else $error("bus number wrong");
    a_locked_hold: assert property (s_locked_wr ##1 s_quiet_rd |=> $stable(cfg_rd_data_out))
        else $error("locked write changed value");
endmodule

bind config_window_base_decoders config_window_base_decoders_props props_u (.ref_clk_in,
    .rst_b_in, .cfg_wr_in, .cfg_rd_offset_in, .cfg_rd_data_out, .lock_mode_in,
    .rc_global_enable_in, .enh_cfg_len_in, .mem_req_in, .decode_out, .claimed_out);

// >>> verification/host_model.sv
// host side model: issues config cycles and memory requests
// assumes the decoders sample on the rising edge; it drives on the falling one
module host_model
    import window_decode_pkg::*;
(
    // clock
    input wire logic ref_clk_in,
    // requests
    output window_decode_pkg::cfg_write_type cfg_wr_out,
    output logic [7:0] cfg_rd_offset_out,
    output window_decode_pkg::mem_req_type mem_req_out,
    // answers
    input wire logic [31:0] cfg_rd_data_in,
    input wire window_decode_pkg::decode_type decode_in,
    input wire logic claimed_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cfg_wr_out = '0;
        cfg_rd_offset_out = 8'hff;
        mem_req_out = '0;
    end
    // idle cycles carry inverted data so a stale value never looks live
    task automatic cfg_write(input logic [7:0] ofs, input logic [31:0] dat);
        @(negedge ref_clk_in);
        cfg_wr_out <= {1'b1, ofs, dat, 4'hf};
        @(negedge ref_clk_in);
        cfg_wr_out <= {1'b0, ~ofs, ~dat, 4'h0};
    endtask
    task automatic cfg_read(input logic [7:0] ofs, output logic [31:0] dat);
        @(negedge ref_clk_in);
        cfg_rd_offset_out <= ofs;
        @(negedge ref_clk_in);
        dat = cfg_rd_data_in;
    endtask
    task automatic mem_probe(input logic [35:0] adr, output decode_type res, output logic clm);
        @(negedge ref_clk_in);
        mem_req_out <= {1'b1, adr};
        @(negedge ref_clk_in);
        res = decode_in;
        clm = claimed_in;
        mem_req_out <= {1'b0, ~adr};
    endtask
endmodule

// >>> verification/config_window_base_decoders_bench.sv
// testbench for the window decoders, host model issues all cycles
// assumes the checker is bound to the design from its own file
module config_window_base_decoders_bench
    import window_decode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic lock_mode_in = 1'b0;
    logic rc_global_enable_in = 1'b0;
    win_len_type enh_cfg_len_in = LEN_256MB;
    cfg_write_type cfg_wr;
    mem_req_type mem_req;
    decode_type decode;
    logic [7:0] rd_ofs;
    logic [31:0] rd_data;
    logic [31:0] d;
    logic claimed;
    logic c;
    decode_type r;
    int fails = 0;
    int comparisons = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    config_window_base_decoders dut_u (.ref_clk_in, .rst_b_in, .cfg_wr_in(cfg_wr),
        .cfg_rd_offset_in(rd_ofs), .cfg_rd_data_out(rd_data), .lock_mode_in,
        .rc_global_enable_in, .enh_cfg_len_in, .mem_req_in(mem_req),
        .decode_out(decode), .claimed_out(claimed));
    host_model host_u (.ref_clk_in, .cfg_wr_out(cfg_wr), .cfg_rd_offset_out(rd_ofs),
        .mem_req_out(mem_req), .cfg_rd_data_in(rd_data), .decode_in(decode),
        .claimed_in(claimed));
    ////////////////////////////////////////////////////////////
    task automatic cmp(input string name, input logic [35:0] exp, input logic [35:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd_check(input logic [7:0] ofs, input logic [31:0] exp);
        host_u.cfg_read(ofs, d);
        cmp("read data", {4'h0, exp}, {4'h0, d});
    endtask
    // hits are {ingress, trusted, claimed}; slot fields only on a trusted hit
    task automatic probe_check(input logic [35:0] a, input logic [2:0] hits, input logic [7:0] bus);
        host_u.mem_probe(a, r, c);
        cmp("hits", {33'h0, hits}, {33'h0, r.ingress_hit, r.trusted_hit, c});
        if (hits[1])
            cmp("slot", {8'h0, bus, a[19:0]}, {8'h0, r.bus, r.dev, r.func, r.reg_ofs});
    endtask
    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (5000) @(posedge ref_clk_in);
        fails++;
        summarize();
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge ref_clk_in);
        rst_b_in <= 1'b1;
        rd_check(INGRESS_BASE_OFS, 32'h0);
        rd_check(INGRESS_BASE_OFS + 8'h4, 32'h0);
        rd_check(TRUSTED_BASE_OFS, TRUSTED_RESET[31:0]);
        rd_check(TRUSTED_BASE_OFS + 8'h4, 32'h0);
        probe_check({8'h0e, 8'hda, 5'd3, 3'd5, 12'h123}, 3'b011, 8'hda);
        // ingress window kept below 4 gb, global enable still off
        host_u.cfg_write(INGRESS_BASE_OFS, 32'h1234_5001);
        probe_check(36'h0_1234_5abc, 3'b000, 8'h0);
        rc_global_enable_in <= 1'b1;
        probe_check(36'h0_1234_5abc, 3'b101, 8'h0);
        probe_check(36'h0_1234_6abc, 3'b000, 8'h0);
        rd_check(INGRESS_BASE_OFS, 32'h1234_5001);
        // trusted base 0f with both mask bits set, size aligned; sweep every length
        host_u.cfg_write(TRUSTED_BASE_OFS, 32'hfc00_0000);
        for (int i = 0; i < 4; i++)
        begin
            enh_cfg_len_in <= win_len_type'(i);
            // address bits 27:26 run 11, 10, 01; smaller windows compare more of them
            for (int j = 0; j < 3; j++)
            begin
                probe_check({8'h0f, 2'(3 - j), 6'h1a, 20'h1d123},
                    {1'b0, {2{i + j < 3}}}, {2'(3 - j), 6'h1a} & (8'hff >> i));
            end
            if (i < 3)
                rd_check(TRUSTED_BASE_OFS, {6'h3f << (2 - i), 26'h0});
        end
        // ingress laid over a trusted slot must win alone
        enh_cfg_len_in <= LEN_256MB;
        host_u.cfg_write(INGRESS_BASE_OFS, 32'hfda1_d001);
        probe_check(36'h0_fda1_d123, 3'b101, 8'h0);
        // locked writes leave both registers as they were
        lock_mode_in <= 1'b1;
        rd_check(INGRESS_BASE_OFS, 32'hfda1_d001);
        host_u.cfg_write(INGRESS_BASE_OFS, 32'h0000_0000);
        rd_check(INGRESS_BASE_OFS, 32'hfda1_d001);
        host_u.cfg_write(TRUSTED_BASE_OFS, 32'h1000_0000);
        rd_check(TRUSTED_BASE_OFS, 32'hf000_0000);
        lock_mode_in <= 1'b0;
        host_u.cfg_write(INGRESS_BASE_OFS, 32'hfda1_d000);
        probe_check(36'h0_fda1_d123, 3'b011, 8'hda);
        summarize();
    end
endmodule
